// ### tpu_pkg.sv
// Constants and types of the timer/PWM unit.
// Assumes one system clock and an APB master driving the registers.
// Function
// R1 - Each timer unit times from its own 16-bit counter fed by a prescaler and limited by a modulus.
// R2 - The prescaler divides by 1, 2, 4, 8, 16, 32, 64 or 128 as software selects.
// R3 - A 16-bit software-written modulus register bounds the count range.
// R4 - The counter runs upward freely, or up and down in center-aligned mode.
// R5 - Each unit picks its prescaler source on its own: bus clock, fixed clock or external pin.
// R6 - The fixed clock source is the reference clock divided by two.
// R7 - Software picks the fixed clock only when the clock generator runs from an external reference.
// R8 - Each channel is set alone for input capture, output compare or buffered edge-aligned PWM.
// R9 - Input capture fires on rising, falling or either edge as set.
// R10 - A compare match sets, clears or toggles the channel pin as set.
// R11 - Software selects the polarity of each PWM output.
// R12 - One bit per unit puts all its channels into buffered center-aligned PWM; channels set to MODE_OFF stay off instead.
// R13 - There are two units, one with one channel and one with four, five channels in all.
// R14 - Each unit raises one interrupt per channel plus one terminal-count interrupt.
// R15 - Each channel owns one pin shared with a general-purpose port bit.
// R16 - Up mode wraps to zero after the modulus; center mode turns at the modulus and at zero.
// R17 - The terminal-count flag sets on wrap or turn, a channel flag on each capture or compare.
package tpu_pkg;
    localparam int CNT_W = 16;
    localparam int NUM_UNITS = 2;
    localparam int CH_A = 1;
    localparam int CH_B = 4;
    localparam int PRE_W = 7;
    localparam int PS_W = 3;
    localparam int ADDR_W = 8;
    localparam int CTRL_W = 6;
    localparam int CHCTL_W = 4;
    localparam int CH_STRIDE = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CNT = 8'h04;
    localparam logic [7:0] OFF_MOD = 8'h08;
    localparam logic [7:0] OFF_CHAN = 8'h20;
    localparam logic [7:0] OFF_STAT = 8'h60;
    localparam logic [7:0] OFF_MASK = 8'h64;
    localparam int UNIT_BIT = 4;
    localparam int CHVAL_BIT = 2;
    localparam int CH_IDX_LSB = 3;
    localparam int CTRL_PS_LSB = 0;
    localparam int CTRL_CLK_LSB = 3;
    localparam int CTRL_CENTER_ALIGNED_PWM = 5;
    localparam int CH_MODE_LSB = 0;
    localparam int CH_EDGE_LSB = 2;
    localparam int PWM_POL_BIT = 0;
    localparam int CAP_RISE_BIT = 0;
    localparam int CAP_FALL_BIT = 1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [CHCTL_W-1:0] CHCTL_RST = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;
    typedef enum logic [1:0] {
        CLK_OFF = 2'b00, CLK_BUS = 2'b01, CLK_FIX = 2'b10, CLK_EXT = 2'b11
    } tpu_clk_t;
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00, MODE_CAPT = 2'b01, MODE_COMP = 2'b10, MODE_PWM = 2'b11
    } tpu_mode_t;
    typedef enum logic [1:0] {
        ACT_NONE = 2'b00, ACT_TOGGLE = 2'b01, ACT_CLEAR = 2'b10, ACT_SET = 2'b11
    } tpu_act_t;
    typedef enum logic [2:0] {
        REG_NONE = 3'b000, REG_CTRL = 3'b001, REG_CNT = 3'b010, REG_MOD = 3'b011,
        REG_CHCTL = 3'b100, REG_CHVAL = 3'b101, REG_STAT = 3'b110, REG_MASK = 3'b111
    } tpu_reg_t;
endpackage

// ### tpu_chan.sv
// One timer channel: capture, compare, edge or center PWM.
// Assumes counter, tick and edge strobes arrive synchronous to clk_sys.
`timescale 1ns/1ps
module tpu_chan (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic [1:0] mode, // Channel mode
    input wire logic [1:0] edge_sel, // Edge, action or polarity field
    input wire logic center_aligned_pwm, // Unit in center-aligned PWM
    input wire logic [tpu_pkg::CNT_W-1:0] cnt, // Unit counter
    input wire logic tick, // Counter advances this cycle
    input wire logic period, // Period boundary of the unit
    input wire logic val_wr, // Software writes the value
    input wire logic [tpu_pkg::CNT_W-1:0] wdata, // Written value
    input wire logic pin_rise, // Pin rising edge, synchronised
    input wire logic pin_fall, // Pin falling edge, synchronised
    output logic [tpu_pkg::CNT_W-1:0] val_rd, // Value for readback
    output logic pin_out, // Pin drive level
    output logic pin_oe, // Channel owns the pin
    output logic event_pulse // Capture or compare event
);
    logic [tpu_pkg::CNT_W-1:0] val_act, val_buf, next_act, next_buf;
    logic next_out, next_oe, next_ev, pwm_like, match, lt;

    always_comb begin
        pwm_like = (tpu_pkg::tpu_mode_t'(mode) != tpu_pkg::MODE_OFF)
            && (center_aligned_pwm || tpu_pkg::tpu_mode_t'(mode) == tpu_pkg::MODE_PWM); // see R12
        match = tick && (cnt == val_act);
        lt = cnt < val_act;
        next_act = val_act;
        next_buf = val_buf;
        next_out = pin_out;
        next_oe = 1'b0;
        next_ev = 1'b0;
        if (pwm_like) begin
            next_oe = 1'b1; // see R15
            next_out = edge_sel[tpu_pkg::PWM_POL_BIT] ? lt : !lt; // see R11
            next_ev = match;
            if (period) begin
                next_act = val_buf; // see R8
            end
        end else begin
            unique case (tpu_pkg::tpu_mode_t'(mode)) // see R8
                tpu_pkg::MODE_CAPT: begin
                    next_ev = (edge_sel[tpu_pkg::CAP_RISE_BIT] && pin_rise)
                        || (edge_sel[tpu_pkg::CAP_FALL_BIT] && pin_fall); // see R9
                    if (next_ev) begin
                        next_act = cnt;
                    end
                end
                tpu_pkg::MODE_COMP: begin
                    next_oe = 1'b1;
                    next_ev = match; // see R17
                    if (match) begin
                        unique case (tpu_pkg::tpu_act_t'(edge_sel)) // see R10
                            tpu_pkg::ACT_TOGGLE: next_out = !pin_out;
                            tpu_pkg::ACT_CLEAR: next_out = 1'b0;
                            tpu_pkg::ACT_SET: next_out = 1'b1;
                            tpu_pkg::ACT_NONE: next_out = pin_out;
                        endcase
                    end
                end
                tpu_pkg::MODE_OFF, tpu_pkg::MODE_PWM: begin
                    next_oe = 1'b0;
                end
            endcase
        end
        if (val_wr) begin
            next_buf = wdata;
            if (!pwm_like) begin
                next_act = wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            val_act <= tpu_pkg::CNT_ZERO;
            val_buf <= tpu_pkg::CNT_ZERO;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            event_pulse <= 1'b0;
        end else begin
            val_act <= next_act;
            val_buf <= next_buf;
            pin_out <= next_out;
            pin_oe <= next_oe;
            event_pulse <= next_ev;
        end
    end

    assign val_rd = pwm_like ? val_buf : val_act;

    capture_value_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R9
        (!pwm_like && mode == tpu_pkg::MODE_CAPT && edge_sel[tpu_pkg::CAP_RISE_BIT] && pin_rise && !val_wr)
        |=> (val_act == $past(cnt)) && event_pulse)
        else $error("capture did not latch the counter");
    compare_toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R10
        (!pwm_like && mode == tpu_pkg::MODE_COMP && match && edge_sel == tpu_pkg::ACT_TOGGLE)
        |=> (pin_out != $past(pin_out)) && event_pulse)
        else $error("compare toggle missed");
    pwm_reload_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R8
        (pwm_like && period && !val_wr) |=> val_act == $past(val_buf))
        else $error("buffered duty not loaded at period");
endmodule

// ### tpu_top.sv
// Two timer/PWM units with APB registers and one interrupt line.
// Assumes APB master on clk_sys; pins and clocks in are asynchronous.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module tpu_top #(
    parameter int CH_A = tpu_pkg::CH_A, // Channels of unit a
    parameter int CH_B = tpu_pkg::CH_B // Channels of unit b
) (
    input wire logic clk_sys, // System clock, 50 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [tpu_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic reference_clock, // Oscillator reference clock
    input wire logic [tpu_pkg::NUM_UNITS-1:0] ext_clk_pin, // External count pins
    input wire logic [CH_A+CH_B-1:0] timer_channel_pin_in, // Channel pin levels
    output logic [CH_A+CH_B-1:0] timer_channel_pin_out, // Channel pin drive
    output logic [CH_A+CH_B-1:0] timer_channel_pin_oe, // Timer owns pin
    output logic irq // Interrupt, active high level
);
    localparam int NC = CH_A + CH_B;
    localparam int NU = tpu_pkg::NUM_UNITS;
    localparam int SW = NU + NC;
    localparam int IW = 1 + NU + NC;
    localparam logic [7:0] CHAN_END = 8'(32'(tpu_pkg::OFF_CHAN) + NC * tpu_pkg::CH_STRIDE);

    logic [1:0] rst_pipe;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // Two-stage sync, third stage only for edges
    logic [IW-1:0] in_raw, in_meta, in_sync, in_prev, in_rise, in_fall;
    assign in_raw = {timer_channel_pin_in, ext_clk_pin, reference_clock};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            in_meta <= '0;
            in_sync <= '0;
            in_prev <= '0;
        end else begin
            in_meta <= in_raw;
            in_sync <= in_meta;
            in_prev <= in_sync;
        end
    end
    assign in_rise = in_sync & ~in_prev;
    assign in_fall = ~in_sync & in_prev;

    logic half, next_half, fix_tick;
    always_comb begin
        next_half = half ^ in_rise[0];
        fix_tick = in_rise[0] && half; // see R6
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            half <= 1'b0;
        end else begin
            half <= next_half;
        end
    end

    function automatic tpu_pkg::tpu_reg_t reg_kind(input logic [7:0] a);
        tpu_pkg::tpu_reg_t k;
        k = tpu_pkg::REG_NONE;
        if (a[1:0] == 2'b00) begin
            if (a < tpu_pkg::OFF_CHAN) begin
                if (a[3:0] == tpu_pkg::OFF_CTRL[3:0]) begin
                    k = tpu_pkg::REG_CTRL;
                end else if (a[3:0] == tpu_pkg::OFF_CNT[3:0]) begin
                    k = tpu_pkg::REG_CNT;
                end else if (a[3:0] == tpu_pkg::OFF_MOD[3:0]) begin
                    k = tpu_pkg::REG_MOD;
                end
            end else if (a < CHAN_END) begin
                k = a[tpu_pkg::CHVAL_BIT] ? tpu_pkg::REG_CHVAL : tpu_pkg::REG_CHCTL;
            end else if (a == tpu_pkg::OFF_STAT) begin
                k = tpu_pkg::REG_STAT;
            end else if (a == tpu_pkg::OFF_MASK) begin
                k = tpu_pkg::REG_MASK;
            end
        end
        return k;
    endfunction

    function automatic logic [2:0] reg_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - tpu_pkg::OFF_CHAN;
        return (a < tpu_pkg::OFF_CHAN) ? {2'b00, a[tpu_pkg::UNIT_BIT]} : d[tpu_pkg::CH_IDX_LSB +: 3];
    endfunction

    tpu_pkg::tpu_reg_t kind;
    logic [2:0] idx;
    logic wr_ok;
    assign kind = reg_kind(paddr);
    assign idx = reg_idx(paddr);
    assign wr_ok = psel && penable && pwrite && pready && (kind != tpu_pkg::REG_NONE);

    // Counter units
    logic [NU-1:0][tpu_pkg::CTRL_W-1:0] ctrl, next_ctrl;
    logic [NU-1:0][tpu_pkg::CNT_W-1:0] cnt, next_cnt, modv, next_modv;
    logic [NU-1:0][tpu_pkg::PRE_W-1:0] pres, next_pres;
    logic [NU-1:0] down, next_down, tick, tc_ev, center_aligned_pwm, src;
    always_comb begin
        logic [tpu_pkg::CNT_W-1:0] lim;
        logic [tpu_pkg::PRE_W-1:0] pmask;
        lim = '1;
        pmask = '0;
        for (int u = 0; u < NU; u++) begin
            next_ctrl[u] = ctrl[u];
            next_modv[u] = modv[u];
            next_cnt[u] = cnt[u];
            next_pres[u] = pres[u];
            next_down[u] = down[u];
            tc_ev[u] = 1'b0;
            center_aligned_pwm[u] = ctrl[u][tpu_pkg::CTRL_CENTER_ALIGNED_PWM];
            unique case (tpu_pkg::tpu_clk_t'(ctrl[u][tpu_pkg::CTRL_CLK_LSB +: 2])) // see R5
                tpu_pkg::CLK_BUS: src[u] = 1'b1;
                tpu_pkg::CLK_FIX: src[u] = fix_tick;
                tpu_pkg::CLK_EXT: src[u] = in_rise[1 + u];
                tpu_pkg::CLK_OFF: src[u] = 1'b0;
            endcase
            lim = (modv[u] == tpu_pkg::CNT_ZERO) ? '1 : modv[u]; // see R3
            pmask = (tpu_pkg::PRE_ONE << ctrl[u][tpu_pkg::CTRL_PS_LSB +: tpu_pkg::PS_W]) - tpu_pkg::PRE_ONE;
            tick[u] = src[u] && (pres[u] == pmask); // see R2
            if (src[u]) begin
                next_pres[u] = tick[u] ? '0 : pres[u] + tpu_pkg::PRE_ONE;
            end
            if (tick[u]) begin // see R1
                if (!center_aligned_pwm[u]) begin // see R4
                    if (cnt[u] >= lim) begin
                        next_cnt[u] = tpu_pkg::CNT_ZERO; // see R16
                        tc_ev[u] = 1'b1; // see R17
                    end else begin
                        next_cnt[u] = cnt[u] + tpu_pkg::CNT_ONE;
                    end
                end else if (!down[u]) begin
                    if (cnt[u] >= lim) begin
                        next_down[u] = 1'b1; // see R16
                        next_cnt[u] = cnt[u] - tpu_pkg::CNT_ONE;
                        tc_ev[u] = 1'b1;
                    end else begin
                        next_cnt[u] = cnt[u] + tpu_pkg::CNT_ONE;
                    end
                end else begin
                    if (cnt[u] == tpu_pkg::CNT_ZERO) begin
                        next_down[u] = 1'b0;
                        next_cnt[u] = tpu_pkg::CNT_ONE;
                        tc_ev[u] = 1'b1;
                    end else begin
                        next_cnt[u] = cnt[u] - tpu_pkg::CNT_ONE;
                    end
                end
            end
            if (wr_ok && idx == 3'(u)) begin
                if (kind == tpu_pkg::REG_CTRL) begin
                    next_ctrl[u] = pwdata[tpu_pkg::CTRL_W-1:0]; // see R12
                end else if (kind == tpu_pkg::REG_MOD) begin
                    next_modv[u] = pwdata[tpu_pkg::CNT_W-1:0];
                end else if (kind == tpu_pkg::REG_CNT) begin
                    // Any write restarts the count
                    next_cnt[u] = tpu_pkg::CNT_ZERO;
                    next_pres[u] = '0;
                    next_down[u] = 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= {NU{tpu_pkg::CTRL_RST}};
            cnt <= '0;
            modv <= '0;
            pres <= '0;
            down <= '0;
        end else begin
            ctrl <= next_ctrl;
            cnt <= next_cnt;
            modv <= next_modv;
            pres <= next_pres;
            down <= next_down;
        end
    end

    // Channels
    logic [NC-1:0][tpu_pkg::CHCTL_W-1:0] chctl, next_chctl;
    logic [NC-1:0][tpu_pkg::CNT_W-1:0] chval_rd;
    logic [NC-1:0] val_wr, ch_ev;
    always_comb begin
        for (int k = 0; k < NC; k++) begin
            val_wr[k] = wr_ok && kind == tpu_pkg::REG_CHVAL && idx == 3'(k);
            next_chctl[k] = (wr_ok && kind == tpu_pkg::REG_CHCTL && idx == 3'(k))
                ? pwdata[tpu_pkg::CHCTL_W-1:0] : chctl[k];
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chctl <= {NC{tpu_pkg::CHCTL_RST}};
        end else begin
            chctl <= next_chctl;
        end
    end

    for (genvar k = 0; k < NC; k++) begin : g_ch // see R13
        localparam int U = (k < CH_A) ? 0 : 1;
        tpu_chan u_ch (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .mode(chctl[k][tpu_pkg::CH_MODE_LSB +: 2]),
            .edge_sel(chctl[k][tpu_pkg::CH_EDGE_LSB +: 2]),
            .center_aligned_pwm(center_aligned_pwm[U]),
            .cnt(cnt[U]),
            .tick(tick[U]),
            .period(tc_ev[U]),
            .val_wr(val_wr[k]),
            .wdata(pwdata[tpu_pkg::CNT_W-1:0]),
            .pin_rise(in_rise[1 + NU + k]),
            .pin_fall(in_fall[1 + NU + k]),
            .val_rd(chval_rd[k]),
            .pin_out(timer_channel_pin_out[k]),
            .pin_oe(timer_channel_pin_oe[k]), // see R15
            .event_pulse(ch_ev[k])
        );
    end

    // Sticky status, write one to clear, set wins
    logic [SW-1:0] stat, next_stat, mask, next_mask;
    logic next_irq;
    always_comb begin
        next_stat = stat;
        next_mask = mask;
        if (wr_ok && kind == tpu_pkg::REG_STAT) begin
            next_stat = stat & ~pwdata[SW-1:0];
        end
        if (wr_ok && kind == tpu_pkg::REG_MASK) begin
            next_mask = pwdata[SW-1:0];
        end
        next_stat = next_stat | {ch_ev, tc_ev}; // see R14
        next_irq = |(next_stat & next_mask);
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stat <= '0;
            mask <= '0;
            irq <= 1'b0;
        end else begin
            stat <= next_stat;
            mask <= next_mask;
            irq <= next_irq;
        end
    end

    // APB answer one cycle after setup
    logic [31:0] next_rdata;
    logic next_ready, next_err;
    always_comb begin
        next_rdata = '0;
        next_err = 1'b0;
        next_ready = psel && !penable;
        if (next_ready) begin
            unique case (kind)
                tpu_pkg::REG_NONE: next_err = 1'b1;
                tpu_pkg::REG_CTRL: next_rdata = 32'(ctrl[idx[0]]);
                tpu_pkg::REG_CNT: next_rdata = 32'(cnt[idx[0]]);
                tpu_pkg::REG_MOD: next_rdata = 32'(modv[idx[0]]);
                tpu_pkg::REG_CHCTL: next_rdata = 32'(chctl[idx]);
                tpu_pkg::REG_CHVAL: next_rdata = 32'(chval_rd[idx]);
                tpu_pkg::REG_STAT: next_rdata = 32'(stat);
                tpu_pkg::REG_MASK: next_rdata = 32'(mask);
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_rdata;
            pready <= next_ready;
            pslverr <= next_err;
        end
    end

    prescale_div_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R2
        (tick[0] && ctrl[0][4:0] == 5'h09 && !wr_ok) |=> !tick[0] ##1 (tick[0] || $past(wr_ok)))
        else $error("divide by two prescale wrong");
    counter_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R1
        (tick[0] && !center_aligned_pwm[0] && cnt[0] < modv[0] && !wr_ok) |=> cnt[0] == $past(cnt[0]) + 16'h0001)
        else $error("counter did not step");
    counter_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R16
        (tick[1] && !center_aligned_pwm[1] && modv[1] != 16'h0000 && cnt[1] == modv[1] && !wr_ok)
        |=> cnt[1] == 16'h0000 ##0 stat[1])
        else $error("counter did not wrap at modulus");
    center_turn_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R4
        (tick[1] && center_aligned_pwm[1] && down[1] && cnt[1] == 16'h0000 && !wr_ok) |=> !down[1] && cnt[1] == 16'h0001)
        else $error("center count did not turn at zero");
    clock_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R5
        (ctrl[1][4:3] == 2'b00 && !wr_ok) |=> $stable(cnt[1]))
        else $error("counter moved with no source");
    tc_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R17
        tc_ev[0] |=> stat[0] ##1 (stat[0] || $past(wr_ok)))
        else $error("terminal count flag not set");
    irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see R14
        (|(stat & mask) && !wr_ok) |=> irq)
        else $error("interrupt not raised");
    apb_ready_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb ready timing wrong");
endmodule

// ### tpu_pin_model.sv
// Far side of the timer pins: reference clock, external count clocks, channel pin levels.
// Assumes the bench sets the level of free pins; an owned pin reads back the timer drive.
`timescale 1ns/1ps
module tpu_pin_model (
    input wire logic ext_run, // Run the external count clocks
    input wire logic [4:0] drive, // Level on pins the timer does not own
    input wire logic [4:0] pin_out, // Timer pin drive
    input wire logic [4:0] pin_oe, // Timer owns pin
    output logic reference_clock, // Oscillator reference, 10 MHz
    output logic [1:0] ext_clk_pin, // External count clocks
    output logic [4:0] pin_in // Resolved pin levels
);
    initial begin
        reference_clock = 1'b0;
        // Offset keeps reference edges off the system clock edges
        #5;
        forever #50 reference_clock = ~reference_clock;
    end
    initial begin
        ext_clk_pin = 2'b00;
        forever #80 ext_clk_pin = ext_run ? ~ext_clk_pin : 2'b00;
    end
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule

// ### test_timer_pwm_capture_unit.sv
// Self-checking bench of the timer unit through its APB registers and pins.
// Assumes tpu_top and tpu_pin_model compiled alongside.
`timescale 1ns/1ps
module test_timer_pwm_capture_unit;
    `define CHK(a, b) check(32'(a), 32'(b))
    logic clk_sys, resetn, psel, penable, pwrite, ext_run, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, reference_clock, irq;
    logic [1:0] ext_clk_pin;
    logic [4:0] drive, pin_in, pin_out, pin_oe;
    int n_mismatch, comparisons, k, hi, t;
    tpu_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_clock(reference_clock), .ext_clk_pin(ext_clk_pin), .timer_channel_pin_in(pin_in),
        .timer_channel_pin_out(pin_out), .timer_channel_pin_oe(pin_oe), .irq(irq));
    tpu_pin_model i_pins (.ext_run(ext_run), .drive(drive), .pin_out(pin_out), .pin_oe(pin_oe),
        .reference_clock(reference_clock), .ext_clk_pin(ext_clk_pin), .pin_in(pin_in));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk_sys);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Count rate of unit a over 200 cycles
    task automatic rate(input logic [31:0] ctrl, input int lo, input int hi_lim);
        apb(1'b1, 8'h00, ctrl);
        apb(1'b1, 8'h04, 32'h0);
        repeat (200) @(posedge clk_sys);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd >= lo && rd <= hi_lim, 1'b1);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end
    initial begin
        {resetn, psel, penable, pwrite, ext_run, paddr, pwdata, drive} = '0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0);
        apb(1'b0, 8'h70, 32'h0);
        `CHK({err, rd[30:0]}, 32'h80000000);
        for (k = 0; k < 8; k++) rate(32'h08 | k, 200 >> k, (208 >> k) + 1);
        rate(32'h10, 18, 22);
        ext_run <= 1'b1;
        rate(32'h18, 23, 28);
        ext_run <= 1'b0;
        apb(1'b1, 8'h08, 32'h3);
        apb(1'b1, 8'h00, 32'h08);
        for (k = 0; k < 6; k++) begin
            apb(1'b0, 8'h04, 32'h0);
            `CHK(rd <= 3, 1'b1);
        end
        apb(1'b0, 8'h60, 32'h0);
        `CHK({irq, rd[0]}, 2'b01);
        apb(1'b1, 8'h64, 32'h1);
        `CHK(irq, 1'b1);
        apb(1'b1, 8'h24, 32'h2);
        apb(1'b1, 8'h20, 32'hE);
        repeat (10) @(posedge clk_sys);
        `CHK({pin_oe[0], pin_out[0]}, 2'b11);
        apb(1'b1, 8'h20, 32'hA);
        repeat (10) @(posedge clk_sys);
        `CHK(pin_out[0], 1'b0);
        apb(1'b1, 8'h20, 32'h6);
        hi = pin_out[0];
        repeat (4) @(posedge clk_sys);
        `CHK(pin_out[0], !hi);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h60, 32'h7F);
        apb(1'b0, 8'h60, 32'h0);
        `CHK({irq, rd[2:0]}, 4'h0);
        apb(1'b1, 8'h10, 32'h08);
        for (k = 1; k < 4; k++) begin
            apb(1'b1, 8'h28, 32'h1 | (k << 2));
            apb(1'b1, 8'h60, 32'h7F);
            drive <= 5'h02;
            repeat (8) @(posedge clk_sys);
            apb(1'b0, 8'h60, 32'h0);
            `CHK(rd[3], k[0]);
            apb(1'b1, 8'h60, 32'h7F);
            drive <= 5'h00;
            repeat (8) @(posedge clk_sys);
            apb(1'b0, 8'h60, 32'h0);
            `CHK(rd[3], k[1]);
        end
        apb(1'b1, 8'h18, 32'h3);
        apb(1'b1, 8'h34, 32'h1);
        for (k = 0; k < 2; k++) begin
            apb(1'b1, 8'h30, k ? 32'h3 : 32'h7);
            repeat (20) @(posedge clk_sys);
            hi = 0;
            repeat (8) @(posedge clk_sys) hi += (pin_out[2] === 1'b1);
            `CHK(hi, k ? 6 : 2);
        end
        apb(1'b1, 8'h10, 32'h28);
        apb(1'b1, 8'h60, 32'h7F);
        repeat (4) @(posedge clk_sys);
        apb(1'b0, 8'h60, 32'h0);
        `CHK(rd[1], 1'b1);
        apb(1'b0, 8'h14, 32'h0);
        `CHK(rd <= 3, 1'b1);
        final_report();
    end
endmodule
